/* logic/msi_cap_regs.svh */
`ifndef MSI_CAP_REGS_SVH
`define MSI_CAP_REGS_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define MSI_OFS_HEADER_CONTROL   8'hD0
`define MSI_OFS_LOWER_ADDRESS    8'hD4
`define MSI_OFS_UPPER_ADDRESS    8'hD8
`define MSI_OFS_MESSAGE_PAYLOAD  8'hDC
`define MSI_OFS_EVENT_STATUS     8'hE0
`define MSI_OFS_EVENT_MASK       8'hE4

// ---------------------------------------------------------------
// header and control word fields
// ---------------------------------------------------------------
`define MSI_CAP_ID_VALUE         8'h05
`define MSI_NEXT_PTR_RESET       8'h00
`define MSI_ENABLE_BIT           16
`define MSI_MMC_VALUE            3'h0
`define MSI_MME_LSB              20
`define MSI_MME_RESET            3'h0
`define MSI_WIDE_CAPABLE_VALUE   1'h1

// ---------------------------------------------------------------
// address and payload fields
// ---------------------------------------------------------------
`define MSI_LOWER_ADDR_LSB       2
`define MSI_ADDR_RESET           30'h0000_0000
`define MSI_UPPER_ADDR_RESET     32'h0000_0000
`define MSI_PAYLOAD_RESET        16'h0000

// ---------------------------------------------------------------
// event status and mask bits
// ---------------------------------------------------------------
`define MSI_EVT_SENT_BIT         0
`define MSI_EVT_DROPPED_BIT      1
`define MSI_EVT_WIDTH            2
`define MSI_EVT_RESET            2'h0

`endif

/* logic/msi_cap_pkg.sv */
package msi_cap_pkg;

  // ---------------------------------------------------------------
  // message issue sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MSI_ST_IDLE  = 2'b01,
    MSI_ST_ISSUE = 2'b10
  } msi_state_t;

endpackage

/* logic/msi_cap.sv */
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "msi_cap_regs.svh"

// Overview of operation
// - header low byte reads fixed identifier
// - next pointer resets to zero
// - enable bit gates messages, resets zero
// - multiple message capable reads zero
// - message enable field written, behaviour single
// - wide address capable bit reads one
// - lower address holds bits 31:2 only
// - downstream messages always routed upstream
// - nonzero upper address gives 64-bit write
// - zero upper address gives 32-bit write
// - payload low 16 bits, upper zero
module msi_cap (
  // clock, reset and enable
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        clk_en_in,
  // register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  // port role and interrupt request from the port core
  input  wire logic        downstream_port_in,
  input  wire logic        msi_request_in,
  // posted memory write towards the transaction layer
  output logic             mwr_valid_out,
  input  wire logic        mwr_ready_in,
  output logic      [63:0] mwr_address_out,
  output logic             mwr_wide_out,
  output logic      [31:0] mwr_payload_out,
  output logic             mwr_route_upstream_out,
  // block interrupt
  output logic             irq_out
);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic                        enable_q;
  logic                        enable_d;
  logic [2:0]                  multi_message_enable_q;
  logic [2:0]                  multi_message_enable_d;
  logic [7:0]                  next_capability_pointer_q;
  logic [29:0]                 lower_address_q;
  logic [29:0]                 lower_address_d;
  logic [31:0]                 upper_message_address_q;
  logic [31:0]                 upper_message_address_d;
  logic [15:0]                 message_payload_q;
  logic [15:0]                 message_payload_d;
  logic [`MSI_EVT_WIDTH-1:0]   evt_status_q;
  logic [`MSI_EVT_WIDTH-1:0]   evt_status_d;
  logic [`MSI_EVT_WIDTH-1:0]   evt_mask_q;
  logic [`MSI_EVT_WIDTH-1:0]   evt_mask_d;
  logic [31:0]                 rdata_q;
  logic [31:0]                 rdata_d;
  logic                        irq_q;
  logic                        irq_d;

  // ---------------------------------------------------------------
  // sequencer and message state
  // ---------------------------------------------------------------
  msi_cap_pkg::msi_state_t     state_q;
  msi_cap_pkg::msi_state_t     state_d;
  logic                        pending_q;
  logic                        pending_d;
  logic                        valid_q;
  logic                        valid_d;
  logic [63:0]                 mwr_addr_q;
  logic [63:0]                 mwr_addr_d;
  logic                        mwr_wide_q;
  logic                        mwr_wide_d;
  logic [31:0]                 mwr_payload_q;
  logic [31:0]                 mwr_payload_d;
  logic                        route_up_q;
  logic                        route_up_d;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  wire logic sel_hdr    = (reg_addr_in == `MSI_OFS_HEADER_CONTROL);
  wire logic sel_lower  = (reg_addr_in == `MSI_OFS_LOWER_ADDRESS);
  wire logic sel_upper  = (reg_addr_in == `MSI_OFS_UPPER_ADDRESS);
  wire logic sel_data   = (reg_addr_in == `MSI_OFS_MESSAGE_PAYLOAD);
  wire logic sel_status = (reg_addr_in == `MSI_OFS_EVENT_STATUS);
  wire logic sel_mask   = (reg_addr_in == `MSI_OFS_EVENT_MASK);

  wire logic wr_hdr    = reg_wr_in & sel_hdr;
  wire logic wr_lower  = reg_wr_in & sel_lower;
  wire logic wr_upper  = reg_wr_in & sel_upper;
  wire logic wr_data   = reg_wr_in & sel_data;
  wire logic wr_mask   = reg_wr_in & sel_mask;
  wire logic rd_status = reg_rd_in & sel_status;

  // ---------------------------------------------------------------
  // read data assembly
  // ---------------------------------------------------------------
  // identifier, capable count and wide flag are constants, not flops
  wire logic [31:0] hdr_word = {8'h00,
                                `MSI_WIDE_CAPABLE_VALUE,
                                multi_message_enable_q,
                                `MSI_MMC_VALUE,
                                enable_q,
                                next_capability_pointer_q,
                                `MSI_CAP_ID_VALUE};

  wire logic [31:0] lower_word = {lower_address_q, 2'h0};
  wire logic [31:0] data_word  = {16'h0000, message_payload_q};
  wire logic [31:0] status_word = {{(32-`MSI_EVT_WIDTH){1'b0}}, evt_status_q};
  wire logic [31:0] mask_word   = {{(32-`MSI_EVT_WIDTH){1'b0}}, evt_mask_q};

  // unmapped offsets read as zero
  wire logic [31:0] rd_mux =
    sel_hdr    ? hdr_word :
    sel_lower  ? lower_word :
    sel_upper  ? upper_message_address_q :
    sel_data   ? data_word :
    sel_status ? status_word :
    sel_mask   ? mask_word : 32'h0000_0000;

  assign rdata_d = reg_rd_in ? rd_mux : 32'h0000_0000;

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  assign enable_d = wr_hdr ? reg_wdata_in[`MSI_ENABLE_BIT] : enable_q;

  // stored for read-back only; the sequencer always sends one vector
  assign multi_message_enable_d = wr_hdr ? reg_wdata_in[`MSI_MME_LSB +: 3]
                                         : multi_message_enable_q;

  assign lower_address_d = wr_lower ? reg_wdata_in[31:`MSI_LOWER_ADDR_LSB]
                                    : lower_address_q;

  // a non-zero upper word selects the wide form at the next launch
  assign upper_message_address_d = wr_upper ? reg_wdata_in : upper_message_address_q;

  assign message_payload_d = wr_data ? reg_wdata_in[15:0] : message_payload_q;

  assign evt_mask_d = wr_mask ? reg_wdata_in[`MSI_EVT_WIDTH-1:0] : evt_mask_q;

  // ---------------------------------------------------------------
  // message sequencing
  // ---------------------------------------------------------------
  // a request is accepted only while enabled; others set the sticky dropped status bit
  wire logic req_accept = msi_request_in & enable_q;
  wire logic req_drop   = msi_request_in & ~enable_q;
  wire logic issue_done = (state_q == msi_cap_pkg::MSI_ST_ISSUE) & valid_q & mwr_ready_in;
  wire logic idle       = (state_q == msi_cap_pkg::MSI_ST_IDLE);
  wire logic start      = idle & (req_accept | (pending_q & enable_q));

  // width chosen from the upper word at launch time
  wire logic        use_wide  = (upper_message_address_q != 32'h0000_0000);
  wire logic [63:0] wide_addr = {upper_message_address_q, lower_address_q, 2'h0};
  wire logic [63:0] narr_addr = {32'h0000_0000, lower_address_q, 2'h0};

  // a request during an issue is remembered once; several collapse into one,
  // which matches single-vector semantics where the receiver sees a level event
  assign pending_d = start ? 1'b0 :
                     (req_accept & ~idle) ? 1'b1 :
                     (~enable_q) ? 1'b0 : pending_q;

  always_comb begin
    state_d       = state_q;
    valid_d       = valid_q;
    mwr_addr_d    = mwr_addr_q;
    mwr_wide_d    = mwr_wide_q;
    mwr_payload_d = mwr_payload_q;
    route_up_d    = route_up_q;
    case (state_q)
      msi_cap_pkg::MSI_ST_IDLE: begin
        if (start) begin
          state_d       = msi_cap_pkg::MSI_ST_ISSUE;
          valid_d       = 1'b1;
          mwr_wide_d    = use_wide;
          mwr_addr_d    = use_wide ? wide_addr : narr_addr;
          mwr_payload_d = {16'h0000, message_payload_q};
          // routing ignores the address for downstream ports
          // the address still goes out unchanged; nothing here checks where it points
          route_up_d    = downstream_port_in;
        end
      end
      msi_cap_pkg::MSI_ST_ISSUE: begin
        // snapshot stays stable until the transaction layer takes it
        if (issue_done) begin
          state_d = msi_cap_pkg::MSI_ST_IDLE;
          valid_d = 1'b0;
        end
      end
      default: begin
        state_d = msi_cap_pkg::MSI_ST_IDLE;
        valid_d = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // event status and interrupt
  // ---------------------------------------------------------------
  wire logic [`MSI_EVT_WIDTH-1:0] evt_set = {req_drop, issue_done};

  // one sticky bit per event; set beats the read-clear in the same cycle, so an
  // event that lands on the clearing read is reported by the next read
  generate
    for (genvar i = 0; i < `MSI_EVT_WIDTH; i++) begin : g_evt
      assign evt_status_d[i] = evt_set[i] | (evt_status_q[i] & ~rd_status);
    end
  endgenerate

  assign irq_d = |(evt_status_d & evt_mask_q);

  // ---------------------------------------------------------------
  // flip-flops
  // ---------------------------------------------------------------
  // every flop holds while clk_en_in is low, so a frozen cycle drops its strobes
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      enable_q                  <= 1'b0;
      multi_message_enable_q    <= `MSI_MME_RESET;
      next_capability_pointer_q <= `MSI_NEXT_PTR_RESET;
    end else if (clk_en_in) begin
      enable_q                  <= enable_d;
      multi_message_enable_q    <= multi_message_enable_d;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      lower_address_q           <= `MSI_ADDR_RESET;
      upper_message_address_q   <= `MSI_UPPER_ADDR_RESET;
      message_payload_q         <= `MSI_PAYLOAD_RESET;
      evt_mask_q                <= `MSI_EVT_RESET;
    end else if (clk_en_in) begin
      lower_address_q           <= lower_address_d;
      upper_message_address_q   <= upper_message_address_d;
      message_payload_q         <= message_payload_d;
      evt_mask_q                <= evt_mask_d;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      state_q       <= msi_cap_pkg::MSI_ST_IDLE;
      pending_q     <= 1'b0;
      valid_q       <= 1'b0;
    end else if (clk_en_in) begin
      state_q       <= state_d;
      pending_q     <= pending_d;
      valid_q       <= valid_d;
    end
  end

  // snapshot taken at launch so that later register writes cannot tear a message
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      mwr_addr_q    <= 64'h0000_0000_0000_0000;
      mwr_wide_q    <= 1'b0;
      mwr_payload_q <= 32'h0000_0000;
      route_up_q    <= 1'b0;
    end else if (clk_en_in) begin
      mwr_addr_q    <= mwr_addr_d;
      mwr_wide_q    <= mwr_wide_d;
      mwr_payload_q <= mwr_payload_d;
      route_up_q    <= route_up_d;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      evt_status_q <= `MSI_EVT_RESET;
      irq_q        <= 1'b0;
    end else if (clk_en_in) begin
      evt_status_q <= evt_status_d;
      irq_q        <= irq_d;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      rdata_q      <= 32'h0000_0000;
    end else if (clk_en_in) begin
      rdata_q      <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata_out          = rdata_q;
  assign mwr_valid_out          = valid_q;
  assign mwr_address_out        = mwr_addr_q;
  assign mwr_wide_out           = mwr_wide_q;
  assign mwr_payload_out        = mwr_payload_q;
  assign mwr_route_upstream_out = route_up_q;
  assign irq_out                = irq_q;

endmodule

/* sim/msi_cap_checker.sv */
`timescale 1ns/1ps
`include "msi_cap_regs.svh"
module msi_cap_checker (
  input wire logic        sys_clk_in,
  input wire logic        reset_n_in,
  input wire logic        clk_en_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic        downstream_port_in,
  input wire logic        msi_request_in,
  input wire logic        mwr_valid_out,
  input wire logic        mwr_ready_in,
  input wire logic [63:0] mwr_address_out,
  input wire logic        mwr_wide_out,
  input wire logic [31:0] mwr_payload_out,
  input wire logic        mwr_route_upstream_out,
  input wire logic        irq_out
);
  // shadow of the enable bit, seen only through register writes
  logic en_q;
  wire  wr_ctl = clk_en_in && reg_wr_in && reg_addr_in == `MSI_OFS_HEADER_CONTROL;
  wire  rd_go  = clk_en_in && reg_rd_in;
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) en_q <= 1'b0;
    else if (wr_ctl) en_q <= reg_wdata_in[16];
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  valid_hold_a: assert property (clk_en_in && mwr_valid_out && !mwr_ready_in |=> mwr_valid_out
    && $stable(mwr_address_out) && $stable(mwr_payload_out)) else $error("message changed before accept");
  valid_drop_a: assert property (clk_en_in && mwr_valid_out && mwr_ready_in |=> !mwr_valid_out)
    else $error("message not retired after accept");
  wide_form_a: assert property (mwr_valid_out |-> mwr_wide_out == (mwr_address_out[63:32] != 32'h0))
    else $error("address form wrong");
  addr_align_a: assert property (mwr_valid_out |-> mwr_address_out[1:0] == 2'h0
    && mwr_payload_out[31:16] == 16'h0) else $error("address or payload bits not zero");
  route_up_a: assert property ($rose(mwr_valid_out) |-> mwr_route_upstream_out == $past(downstream_port_in))
    else $error("route flag wrong");
  gate_off_a: assert property (clk_en_in && msi_request_in && !en_q && !mwr_valid_out |=> !mwr_valid_out)
    else $error("message while disabled");
  launch_a: assert property (clk_en_in && msi_request_in && en_q && !mwr_valid_out |=> mwr_valid_out)
    else $error("message not launched");
  header_ro_a: assert property (rd_go && reg_addr_in == `MSI_OFS_HEADER_CONTROL |=>
    {reg_rdata_out[31:23], reg_rdata_out[19:17], reg_rdata_out[15:0]} == {9'h001, 3'h0, 16'h0005})
    else $error("header fixed fields wrong");
  lower_ro_a: assert property (rd_go && reg_addr_in == `MSI_OFS_LOWER_ADDRESS |=> reg_rdata_out[1:0] == 2'h0)
    else $error("lower address low bits set");
  payload_hi_a: assert property (rd_go && reg_addr_in == `MSI_OFS_MESSAGE_PAYLOAD |=>
    reg_rdata_out[31:16] == 16'h0) else $error("payload upper half set");
  cover property (mwr_valid_out && !mwr_ready_in ##1 mwr_valid_out);
  cover property (mwr_valid_out && mwr_wide_out);
  cover property (irq_out);
endmodule

bind msi_cap msi_cap_checker msi_cap_checker_inst (
  .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .downstream_port_in(downstream_port_in), .msi_request_in(msi_request_in), .mwr_valid_out(mwr_valid_out),
  .mwr_ready_in(mwr_ready_in), .mwr_address_out(mwr_address_out), .mwr_wide_out(mwr_wide_out),
  .mwr_payload_out(mwr_payload_out), .mwr_route_upstream_out(mwr_route_upstream_out), .irq_out(irq_out));

/* sim/msi_rc_model.sv */
`timescale 1ns/1ps
module msi_rc_model (
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        stall_in,
  input  wire logic        mwr_valid_in,
  input  wire logic [63:0] mwr_address_in,
  input  wire logic        mwr_wide_in,
  input  wire logic [31:0] mwr_payload_in,
  input  wire logic        mwr_route_upstream_in,
  output logic             mwr_ready_out,
  output logic      [7:0]  accept_count_out,
  output logic      [97:0] last_write_out
);
  // stalling is the slow answer: the write waits until the bench lets go
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      mwr_ready_out    <= 1'b0;
      accept_count_out <= 8'h00;
      last_write_out   <= '0;
    end else begin
      mwr_ready_out <= !stall_in;
      if (mwr_valid_in && mwr_ready_out) begin
        accept_count_out <= accept_count_out + 8'h01;
        last_write_out   <= {mwr_route_upstream_in, mwr_wide_in, mwr_payload_in, mwr_address_in};
      end
    end
  end
endmodule

/* sim/tb_msi_cap.sv */
`timescale 1ns/1ps
module tb_msi_cap;
  logic        sys_clk, reset_n, reg_wr, reg_rd, ds_port, msi_req, stall, clk_en;
  logic [7:0]  reg_addr, cnt;
  logic [31:0] reg_wdata, rdata, payload;
  logic        valid, ready, wide, route, irq;
  logic [63:0] maddr;
  logic [97:0] last;
  int          fails, check_count;

  msi_cap msi_cap_inst (
    .sys_clk_in(sys_clk), .reset_n_in(reset_n), .clk_en_in(clk_en), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata),
    .downstream_port_in(ds_port), .msi_request_in(msi_req), .mwr_valid_out(valid), .mwr_ready_in(ready),
    .mwr_address_out(maddr), .mwr_wide_out(wide), .mwr_payload_out(payload), .mwr_route_upstream_out(route),
    .irq_out(irq));
  msi_rc_model msi_rc_model_inst (
    .sys_clk_in(sys_clk), .reset_n_in(reset_n), .stall_in(stall), .mwr_valid_in(valid),
    .mwr_address_in(maddr), .mwr_wide_in(wide), .mwr_payload_in(payload), .mwr_route_upstream_in(route),
    .mwr_ready_out(ready), .accept_count_out(cnt), .last_write_out(last));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [97:0] got, input logic [97:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so look there
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic pulse;
    @(posedge sys_clk);
    msi_req <= 1'b1;
    @(posedge sys_clk);
    msi_req <= 1'b0;
  endtask
  task automatic wait_cnt(input logic [7:0] n);
    for (int i = 0; i < 60 && cnt !== n; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (cnt !== n) begin
      fails++;
      $display("CHECK FAILED at %0t: message count stuck", $time);
      conclude();
    end
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rd(8'hD0, 32'h0080_0005);
    rd(8'hD4, 32'h0); rd(8'hD8, 32'h0); rd(8'hDC, 32'h0); rd(8'hE0, 32'h0); rd(8'hE4, 32'h0);
  endtask
  task automatic t_access;
    wr(8'hD0, 32'hFFFF_FFFF); rd(8'hD0, 32'h00F1_0005);
    wr(8'hD4, 32'hFFFF_FFFF); rd(8'hD4, 32'hFFFF_FFFC);
    wr(8'hD8, 32'hFFFF_FFFF); rd(8'hD8, 32'hFFFF_FFFF);
    wr(8'hDC, 32'hFFFF_FFFF); rd(8'hDC, 32'h0000_FFFF);
    wr(8'hF0, 32'hFFFF_FFFF); rd(8'hF0, 32'h0);
  endtask
  task automatic t_msg32;
    wr(8'hD8, 32'h0); wr(8'hD4, 32'h1234_5678); wr(8'hDC, 32'hFFFF_ABCD);
    pulse(); wait_cnt(8'h01);
    chk(last, {1'b1, 1'b0, 32'h0000_ABCD, 64'h0000_0000_1234_5678});
    idle(6); chk(cnt, 8'h01);
  endtask
  task automatic t_msg64;
    ds_port <= 1'b0; stall <= 1'b1;
    wr(8'hD8, 32'hDEAD_0001); pulse(); idle(6);
    chk(cnt, 8'h01);
    stall <= 1'b0; wait_cnt(8'h02);
    chk(last, {1'b0, 1'b1, 32'h0000_ABCD, 64'hDEAD_0001_1234_5678});
  endtask
  // requests during a stalled write fold into one pending message
  task automatic t_collapse;
    stall <= 1'b1;
    pulse(); pulse(); pulse(); idle(4);
    chk(cnt, 8'h02);
    stall <= 1'b0; wait_cnt(8'h04); idle(8);
    chk(cnt, 8'h04);
  endtask
  task automatic t_disabled;
    rd(8'hE0, 32'h1); wr(8'hD0, 32'h0); pulse(); idle(6);
    chk(cnt, 8'h04);
    rd(8'hE0, 32'h2); rd(8'hE0, 32'h0);
  endtask
  task automatic t_irq;
    wr(8'hE4, 32'h1); wr(8'hD0, 32'h0001_0000); pulse(); wait_cnt(8'h05); idle(2);
    chk(irq, 1'b1);
    rd(8'hE0, 32'h1); idle(2);
    chk(irq, 1'b0);
    wr(8'hE4, 32'h0); pulse(); wait_cnt(8'h06); idle(2);
    chk(irq, 1'b0);
    rd(8'hE0, 32'h1);
  endtask

  // a frozen clock enable must swallow strobes and requests alike
  task automatic t_freeze;
    clk_en <= 1'b0;
    wr(8'hDC, 32'h0000_1111); pulse(); idle(4);
    chk(cnt, 8'h06);
    chk(valid, 1'b0);
    clk_en <= 1'b1;
    rd(8'hDC, 32'h0000_ABCD);
  endtask
  // reset in mid-run drops a stalled message and restores every register
  task automatic t_reset_mid;
    stall <= 1'b1; pulse(); idle(2);
    chk(valid, 1'b1);
    reset_n <= 1'b0; idle(2);
    reset_n <= 1'b1; stall <= 1'b0;
    chk(valid, 1'b0);
    t_reset();
    wr(8'hE4, 32'h2); pulse(); idle(3);
    chk(cnt, 8'h00);
    chk(irq, 1'b1);
    rd(8'hE0, 32'h2);
  endtask

  initial begin
    reset_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; ds_port = 1'b1; msi_req = 1'b0; stall = 1'b0;
    reg_addr = 8'h00; reg_wdata = 32'h0; fails = 0; check_count = 0; clk_en = 1'b1;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset(); t_access(); t_msg32(); t_msg64(); t_collapse(); t_disabled(); t_irq();
    t_freeze(); t_reset_mid();
    conclude();
  end
endmodule
